// file: src/vovsc_params.svh
// Register offsets, field positions and reset values of the scaling config.
`ifndef VOVSC_PARAMS_SVH
`define VOVSC_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VOVSC_OFS_OUTPUT_FORMAT 12'h048
`define VOVSC_OFS_UPPER_EVEN 12'h04C
`define VOVSC_OFS_LOWER_EVEN 12'h050
`define VOVSC_OFS_FACTORY_TEST 12'h054
`define VOVSC_OFS_AGC_DELAY 12'h060
`define VOVSC_OFS_BURST_DELAY 12'h064
`define VOVSC_OFS_UPPER_ODD 12'h0CC
`define VOVSC_OFS_LOWER_ODD 12'h0D0

// ****************************************************************
// Reset values
// ****************************************************************
`define VOVSC_RST_OUTPUT_FORMAT 8'h00
`define VOVSC_RST_UPPER 8'h60
`define VOVSC_RST_LOWER 8'h00
`define VOVSC_RST_AGC_DELAY 8'h68
`define VOVSC_RST_BURST_DELAY 8'h5D
`define VOVSC_TEST_READ 8'h01

// ****************************************************************
// Field positions
// ****************************************************************
`define VOVSC_BIT_RANGE 7
`define VOVSC_CORE_HI 6
`define VOVSC_CORE_LO 5
`define VOVSC_OUTPUT_FORMAT_CTRL_WMASK 8'hE0
`define VOVSC_BIT_LUMA_LOWPASS 7
`define VOVSC_BIT_CHROMA_COMB 6
`define VOVSC_BIT_INTERLACE 5
`define VOVSC_RATIO_HI_MSB 4

// ****************************************************************
// Luma and chroma limits, coring thresholds
// ****************************************************************
`define VOVSC_LUMA_MIN_LIM 8'h10
`define VOVSC_LUMA_MAX_LIM 8'hFD
`define VOVSC_LUMA_MIN_FULL 8'h00
`define VOVSC_LUMA_MAX_FULL 8'hFF
`define VOVSC_CHROMA_MIN 8'h02
`define VOVSC_CHROMA_MAX 8'hFD
`define VOVSC_CORE_T1 8'h08
`define VOVSC_CORE_T2 8'h10
`define VOVSC_CORE_T3 8'h20

`endif

// file: src/vovsc_pkg.sv
// Types shared by the vertical scaling configuration block.
package vovsc_pkg;
    // Settings of one field copy of the vertical scaler.
    typedef struct packed {
        logic luma_lowpass_only_en;
        logic chroma_comb_en;
        logic interlace_en;
        logic [12:0] vert_ratio;
    } vovsc_vert_ratio_t;

    // Settings of the output formatter.
    typedef struct packed {
        logic full_range;
        logic [1:0] coring_sel;
    } vovsc_format_t;

    typedef enum logic [1:0] {
        VOVSC_IDLE = 2'b00,
        VOVSC_ACK = 2'b01
    } vovsc_bus_state_t;
endpackage : vovsc_pkg

// file: src/vovsc_top.sv
// Output format, vertical scaling and gate delay registers with luma shaping.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`include "vovsc_params.svh"

module vovsc_top
    import vovsc_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Video path
    input wire logic odd_field_i,
    input wire logic [7:0] luma_i,
    input wire logic [7:0] chroma_i,
    output logic [7:0] luma_o,
    output logic [7:0] chroma_o,
    // Settings to the scaler and AGC
    output vovsc_vert_ratio_t vert_ratio_o,
    output vovsc_format_t format_o,
    output logic [7:0] agc_gate_delay_val_o,
    output logic [7:0] burst_gate_delay_val_o
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] output_format_reg;
    logic [7:0] vert_ratio_upper_even_reg;
    logic [7:0] vert_ratio_lower_even_reg;
    logic [7:0] vert_ratio_upper_odd_reg;
    logic [7:0] vert_ratio_lower_odd_reg;
    logic [7:0] agc_gate_delay_val_reg;
    logic [7:0] burst_gate_delay_val_reg;
    vovsc_bus_state_t bus_state_reg;
    logic [31:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr_en;
    logic req;

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Every access acks one cycle after the request; unmapped reads give 0.
    assign req = wb_cyc_i && wb_stb_i && (bus_state_reg == VOVSC_IDLE);
    assign wr_en = req && wb_we_i && wb_sel_i[0];
    assign wb_ack_o = (bus_state_reg == VOVSC_ACK);
    assign wb_dat_o = rdata_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bus_state_reg <= VOVSC_IDLE;
        else
        begin
            // A request still held in the ack cycle is not taken again.
            case (bus_state_reg)
                VOVSC_IDLE:
                    bus_state_reg <= req ? VOVSC_ACK : VOVSC_IDLE;
                VOVSC_ACK:
                    bus_state_reg <= VOVSC_IDLE;
                default:
                    bus_state_reg <= VOVSC_IDLE;
            endcase
        end
    end

    always_comb
    begin
        case (wb_adr_i[11:0])
            `VOVSC_OFS_OUTPUT_FORMAT: rdata_next = output_format_reg;
            `VOVSC_OFS_UPPER_EVEN: rdata_next = vert_ratio_upper_even_reg;
            `VOVSC_OFS_LOWER_EVEN: rdata_next = vert_ratio_lower_even_reg;
            `VOVSC_OFS_FACTORY_TEST: rdata_next = `VOVSC_TEST_READ;
            `VOVSC_OFS_AGC_DELAY: rdata_next = agc_gate_delay_val_reg;
            `VOVSC_OFS_BURST_DELAY: rdata_next = burst_gate_delay_val_reg;
            `VOVSC_OFS_UPPER_ODD: rdata_next = vert_ratio_upper_odd_reg;
            `VOVSC_OFS_LOWER_ODD: rdata_next = vert_ratio_lower_odd_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_reg <= 32'h00000000;
        else if (req && !wb_we_i)
            rdata_reg <= {24'h000000, rdata_next};
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Reserved format bits are not stored, so a stray write cannot
    // disturb them. Test register writes are dropped for the same reason.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            output_format_reg <= `VOVSC_RST_OUTPUT_FORMAT;
        else if (wr_en && wb_adr_i == `VOVSC_OFS_OUTPUT_FORMAT)
            output_format_reg <= wb_dat_i[7:0] & `VOVSC_OUTPUT_FORMAT_CTRL_WMASK;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vert_ratio_upper_even_reg <= `VOVSC_RST_UPPER;
            vert_ratio_lower_even_reg <= `VOVSC_RST_LOWER;
            vert_ratio_upper_odd_reg <= `VOVSC_RST_UPPER;
            vert_ratio_lower_odd_reg <= `VOVSC_RST_LOWER;
        end
        else if (wr_en)
        begin
            if (wb_adr_i == `VOVSC_OFS_UPPER_EVEN)
                vert_ratio_upper_even_reg <= wb_dat_i[7:0];
            if (wb_adr_i == `VOVSC_OFS_LOWER_EVEN)
                vert_ratio_lower_even_reg <= wb_dat_i[7:0];
            if (wb_adr_i == `VOVSC_OFS_UPPER_ODD)
                vert_ratio_upper_odd_reg <= wb_dat_i[7:0];
            if (wb_adr_i == `VOVSC_OFS_LOWER_ODD)
                vert_ratio_lower_odd_reg <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            agc_gate_delay_val_reg <= `VOVSC_RST_AGC_DELAY;
            burst_gate_delay_val_reg <= `VOVSC_RST_BURST_DELAY;
        end
        else if (wr_en)
        begin
            if (wb_adr_i == `VOVSC_OFS_AGC_DELAY)
                agc_gate_delay_val_reg <= wb_dat_i[7:0];
            if (wb_adr_i == `VOVSC_OFS_BURST_DELAY)
                burst_gate_delay_val_reg <= wb_dat_i[7:0];
        end
    end

    // ****************************************************************
    // Scaler settings for the current field
    // ****************************************************************
    logic [7:0] upper_sel;
    logic [7:0] lower_sel;
    vovsc_vert_ratio_t vert_ratio_next;

    always_comb
    begin
        upper_sel = odd_field_i ? vert_ratio_upper_odd_reg
                                : vert_ratio_upper_even_reg;
        lower_sel = odd_field_i ? vert_ratio_lower_odd_reg
                                : vert_ratio_lower_even_reg;
        // Set means lowpass only; clear means filter and interpolate.
        vert_ratio_next.luma_lowpass_only_en =
            upper_sel[`VOVSC_BIT_LUMA_LOWPASS];
        vert_ratio_next.chroma_comb_en = upper_sel[`VOVSC_BIT_CHROMA_COMB];
        vert_ratio_next.interlace_en = upper_sel[`VOVSC_BIT_INTERLACE];
        vert_ratio_next.vert_ratio =
            {upper_sel[`VOVSC_RATIO_HI_MSB:0], lower_sel};
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            vert_ratio_o <= '0;
            format_o <= '0;
            agc_gate_delay_val_o <= 8'h00;
            burst_gate_delay_val_o <= 8'h00;
        end
        else
        begin
            vert_ratio_o <= vert_ratio_next;
            format_o.full_range <= output_format_reg[`VOVSC_BIT_RANGE];
            format_o.coring_sel <=
                output_format_reg[`VOVSC_CORE_HI:`VOVSC_CORE_LO];
            agc_gate_delay_val_o <= agc_gate_delay_val_reg;
            burst_gate_delay_val_o <= burst_gate_delay_val_reg;
        end
    end

    // ****************************************************************
    // Luma coring and range limiting
    // ****************************************************************
    logic [7:0] core_thr;
    logic [7:0] luma_cored;
    logic [7:0] luma_lo;
    logic [7:0] luma_hi;
    logic [7:0] luma_next;
    logic [7:0] chroma_next;

    always_comb
    begin
        case (output_format_reg[`VOVSC_CORE_HI:`VOVSC_CORE_LO])
            2'h1: core_thr = `VOVSC_CORE_T1;
            2'h2: core_thr = `VOVSC_CORE_T2;
            2'h3: core_thr = `VOVSC_CORE_T3;
            default: core_thr = 8'h00;
        endcase
        luma_cored = (luma_i < core_thr) ? 8'h00 : luma_i;
        if (output_format_reg[`VOVSC_BIT_RANGE])
        begin
            luma_lo = `VOVSC_LUMA_MIN_FULL;
            luma_hi = `VOVSC_LUMA_MAX_FULL;
        end
        else
        begin
            luma_lo = `VOVSC_LUMA_MIN_LIM;
            luma_hi = `VOVSC_LUMA_MAX_LIM;
        end
        // Coring to zero wins in full range; limited range lifts to black.
        if (luma_cored < luma_lo)
            luma_next = luma_lo;
        else if (luma_cored > luma_hi)
            luma_next = luma_hi;
        else
            luma_next = luma_cored;
        if (chroma_i < `VOVSC_CHROMA_MIN)
            chroma_next = `VOVSC_CHROMA_MIN;
        else if (chroma_i > `VOVSC_CHROMA_MAX)
            chroma_next = `VOVSC_CHROMA_MAX;
        else
            chroma_next = chroma_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            luma_o <= 8'h00;
            chroma_o <= 8'h00;
        end
        else
        begin
            luma_o <= luma_next;
            chroma_o <= chroma_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_ack_one_cycle: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle pulse");
    a_test_read_value: assert property (
        req && !wb_we_i && wb_adr_i == `VOVSC_OFS_FACTORY_TEST
        |=> wb_dat_o == 32'h00000001)
        else $error("test register did not read 0x01");
    a_luma_limited: assert property (
        rst_n_i && !output_format_reg[`VOVSC_BIT_RANGE] &&
        $stable(output_format_reg)
        |=> luma_o >= 8'h10 && luma_o <= 8'hFD)
        else $error("luma outside limited range");
    a_chroma_limit: assert property (
        rst_n_i |=> chroma_o >= 8'h02 && chroma_o <= 8'hFD)
        else $error("chroma outside limits");
    a_full_range_pass: assert property (
        output_format_reg == 8'h80 |=> luma_o == $past(luma_i))
        else $error("full range luma altered");
    a_coring_zero: assert property (
        output_format_reg == 8'hE0 && luma_i < 8'h20 |=> luma_o == 8'h00)
        else $error("coring did not zero luma");
    a_ratio_even: assert property (
        rst_n_i && !odd_field_i |=> vert_ratio_o.vert_ratio ==
        {$past(vert_ratio_upper_even_reg[4:0]),
         $past(vert_ratio_lower_even_reg)})
        else $error("even ratio wrong");
    a_ratio_odd: assert property (
        odd_field_i |=> vert_ratio_o.interlace_en ==
        $past(vert_ratio_upper_odd_reg[5]))
        else $error("odd copy not applied");
    a_format_reserved: assert property (
        output_format_reg[4:0] == 5'h00)
        else $error("reserved format bits stored");
    a_agc_delay_out: assert property (
        rst_n_i |=> agc_gate_delay_val_o == $past(agc_gate_delay_val_reg))
        else $error("agc gate delay output stale");
    a_burst_delay_out: assert property (
        rst_n_i |=> burst_gate_delay_val_o ==
        $past(burst_gate_delay_val_reg))
        else $error("burst gate delay output stale");
    a_lowpass_odd: assert property (
        odd_field_i |=> vert_ratio_o.luma_lowpass_only_en ==
        $past(vert_ratio_upper_odd_reg[`VOVSC_BIT_LUMA_LOWPASS]))
        else $error("odd lowpass bit not applied");
    a_comb_even: assert property (
        rst_n_i && !odd_field_i |=> vert_ratio_o.chroma_comb_en ==
        $past(vert_ratio_upper_even_reg[`VOVSC_BIT_CHROMA_COMB]))
        else $error("even chroma comb bit not applied");
    a_ratio_odd_value: assert property (
        odd_field_i |=> vert_ratio_o.vert_ratio ==
        {$past(vert_ratio_upper_odd_reg[4:0]),
         $past(vert_ratio_lower_odd_reg)})
        else $error("odd ratio wrong");
    a_format_export: assert property (
        rst_n_i |=> format_o.coring_sel ==
        $past(output_format_reg[`VOVSC_CORE_HI:`VOVSC_CORE_LO]))
        else $error("coring select output stale");
    a_write_lands: assert property (
        wr_en && wb_adr_i == `VOVSC_OFS_AGC_DELAY
        |=> agc_gate_delay_val_reg == $past(wb_dat_i[7:0]))
        else $error("agc delay write lost");

    c_write_upper: cover property (wr_en && wb_adr_i == 12'h04C);
    c_odd_field: cover property (odd_field_i && vert_ratio_o.interlace_en);
    c_limited_black: cover property (!format_o.full_range && luma_o == 8'h10);
    c_full_range: cover property (format_o.full_range);
    c_coring: cover property (format_o.coring_sel == 2'h3);

endmodule : vovsc_top

// file: verif/vovsc_top_bench.sv
// Self-checking bench for the output format and vertical scaling registers.
`timescale 1ns/10ps
`include "vovsc_params.svh"

module vovsc_top_bench
    import vovsc_pkg::*;
;
    // ****************************************************************
    // Stimulus and observation signals
    // ****************************************************************
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic odd_field_i = 1'b0;
    logic [7:0] luma_i = 8'h00;
    logic [7:0] chroma_i = 8'h00;
    logic [7:0] luma_o;
    logic [7:0] chroma_o;
    vovsc_vert_ratio_t vert_ratio_o;
    vovsc_format_t format_o;
    logic [7:0] agc_gate_delay_val_o;
    logic [7:0] burst_gate_delay_val_o;
    int failures = 0;
    int checks_done = 0;

    vovsc_top vovsc_top_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .odd_field_i(odd_field_i), .luma_i(luma_i),
        .chroma_i(chroma_i), .luma_o(luma_o), .chroma_o(chroma_o),
        .vert_ratio_o(vert_ratio_o), .format_o(format_o),
        .agc_gate_delay_val_o(agc_gate_delay_val_o),
        .burst_gate_delay_val_o(burst_gate_delay_val_o)
    );

    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp,
               input string what);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask : check

    // Called just after a rising edge; returns just after one.
    task wb_cycle(input logic we, input logic [11:0] adr,
                  input logic [3:0] sel, input logic [7:0] wd,
                  output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, wd};
        @(posedge clk_i);
        // Values read at the edge are those the design sampled there.
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        check({31'h0, wb_ack_o}, 32'h1, "bus answer");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_cycle

    task wr(input logic [11:0] adr, input logic [7:0] d);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, 4'h1, d, rd);
    endtask : wr

    task rd_chk(input logic [11:0] adr, input logic [7:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 4'h1, 8'h00, rd);
        check(rd, {24'h0, exp}, "register read");
    endtask : rd_chk

    task wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task test_reset();
        rd_chk(`VOVSC_OFS_OUTPUT_FORMAT, 8'h00);
        rd_chk(`VOVSC_OFS_UPPER_EVEN, 8'h60);
        rd_chk(`VOVSC_OFS_LOWER_EVEN, 8'h00);
        rd_chk(`VOVSC_OFS_UPPER_ODD, 8'h60);
        rd_chk(`VOVSC_OFS_LOWER_ODD, 8'h00);
        rd_chk(`VOVSC_OFS_AGC_DELAY, 8'h68);
        rd_chk(`VOVSC_OFS_BURST_DELAY, 8'h5D);
        rd_chk(`VOVSC_OFS_FACTORY_TEST, 8'h01);
        check({16'h0, vert_ratio_o}, {16'h0, 16'h6000}, "reset scaler");
        check({29'h0, format_o}, 32'h0, "reset format");
        check({24'h0, agc_gate_delay_val_o}, 32'h68, "agc out");
        check({24'h0, burst_gate_delay_val_o}, 32'h5D, "burst out");
        $display("test reset values done");
    endtask : test_reset

    task test_regs();
        logic [31:0] rd;
        wr(`VOVSC_OFS_AGC_DELAY, 8'hA7);
        wr(`VOVSC_OFS_BURST_DELAY, 8'h3C);
        // A write with the low byte lane off must leave the value alone.
        wb_cycle(1'b1, `VOVSC_OFS_AGC_DELAY, 4'hE, 8'h11, rd);
        wr(`VOVSC_OFS_OUTPUT_FORMAT, 8'hE0);
        wr(`VOVSC_OFS_FACTORY_TEST, 8'h01);
        wr(12'h058, 8'h55);
        rd_chk(`VOVSC_OFS_AGC_DELAY, 8'hA7);
        rd_chk(`VOVSC_OFS_BURST_DELAY, 8'h3C);
        rd_chk(`VOVSC_OFS_OUTPUT_FORMAT, 8'hE0);
        rd_chk(`VOVSC_OFS_FACTORY_TEST, 8'h01);
        rd_chk(12'h058, 8'h00);
        check({24'h0, agc_gate_delay_val_o}, 32'hA7, "agc out");
        check({24'h0, burst_gate_delay_val_o}, 32'h3C, "burst");
        check({29'h0, format_o}, 32'h7, "format out");
        wr(`VOVSC_OFS_OUTPUT_FORMAT, 8'h00);
        $display("test register access done");
    endtask : test_regs

    task test_field();
        logic [31:0] ratio;
        // Ratio for a halving scale, as software would compute it.
        ratio = (32'h10000 - 32'd512 * (32'd2 - 32'd1)) & 32'h1FFF;
        // Even copy scales a single field, odd copy a full frame.
        wr(`VOVSC_OFS_UPPER_EVEN, {3'b100, ratio[12:8]});
        wr(`VOVSC_OFS_LOWER_EVEN, ratio[7:0]);
        wr(`VOVSC_OFS_UPPER_ODD, 8'h6A);
        wr(`VOVSC_OFS_LOWER_ODD, 8'h34);
        rd_chk(`VOVSC_OFS_UPPER_EVEN, 8'h9E);
        rd_chk(`VOVSC_OFS_LOWER_ODD, 8'h34);
        check({16'h0, vert_ratio_o}, {16'h0, 3'b100, 13'h1E00}, "even");
        odd_field_i <= 1'b1;
        wait_clk(3);
        check({16'h0, vert_ratio_o}, {16'h0, 3'b011, 13'h0A34}, "odd");
        odd_field_i <= 1'b0;
        wait_clk(3);
        check({16'h0, vert_ratio_o}, {16'h0, 3'b100, 13'h1E00}, "back");
        $display("test field copies done");
    endtask : test_field

    function automatic logic [7:0] exp_luma(logic full, logic [1:0] core,
                                            logic [7:0] v);
        logic [7:0] thr;
        logic [7:0] r;
        thr = (core == 2'd0) ? 8'd0 : (8'd4 << core);
        r = (v < thr) ? 8'd0 : v;
        if (!full)
        begin
            r = (r < 8'd16) ? 8'd16 : ((r > 8'd253) ? 8'd253 : r);
        end
        return r;
    endfunction : exp_luma

    task test_luma();
        logic [7:0] vals[10];
        logic [7:0] c;
        vals = '{8'd0, 8'd7, 8'd8, 8'd15, 8'd16, 8'd31, 8'd32, 8'd200,
                 8'd254, 8'd255};
        for (int f = 0; f < 2; f++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                wr(`VOVSC_OFS_OUTPUT_FORMAT, {f[0], k[1:0], 5'b00000});
                wait_clk(2);
                for (int i = 0; i < 10; i++)
                begin
                    luma_i <= vals[i];
                    chroma_i <= vals[i];
                    wait_clk(2);
                    c = (vals[i] < 8'd2) ? 8'd2 : vals[i];
                    c = (c > 8'd253) ? 8'd253 : c;
                    check({24'h0, luma_o},
                          {24'h0, exp_luma(f[0], k[1:0], vals[i])},
                          "luma");
                    check({24'h0, chroma_o}, {24'h0, c}, "chroma");
                end
            end
        end
        // Back to the limited range with coring off before the verdict.
        wr(`VOVSC_OFS_OUTPUT_FORMAT, 8'h00);
        $display("test luma shaping done");
    endtask : test_luma

    // ****************************************************************
    // Verdict, watchdog and main sequence
    // ****************************************************************
    task print_verdict();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // The whole run needs about three hundred cycles; twenty thousand is ample.
    initial
    begin
        #(40 * 20000);
        failures++;
        print_verdict();
    end

    initial
    begin
        wait_clk(10);
        rst_n_i <= 1'b1;
        wait_clk(2);
        test_reset();
        test_regs();
        test_field();
        test_luma();
        print_verdict();
    end
endmodule : vovsc_top_bench
